// ==== crt_timing_pkg.sv ====
// constants, register map and configuration layout of the raster timing controller
package crt_timing_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int REFRESH_W = 14;
	localparam int RASTER_W = 5;
	localparam int ROW_W = 7;

	// register word addresses
	localparam logic [4:0] A_HTOTAL = 5'h00;
	localparam logic [4:0] A_HDISP = 5'h01;
	localparam logic [4:0] A_HSYNC_POS = 5'h02;
	localparam logic [4:0] A_HSYNC_WIDTH = 5'h03;
	localparam logic [4:0] A_VTOTAL = 5'h04;
	localparam logic [4:0] A_VADJUST = 5'h05;
	localparam logic [4:0] A_VDISP = 5'h06;
	localparam logic [4:0] A_VSYNC_POS = 5'h07;
	localparam logic [4:0] A_SCAN_MODE = 5'h08;
	localparam logic [4:0] A_MAX_RASTER = 5'h09;
	localparam logic [4:0] A_CUR_START = 5'h0a;
	localparam logic [4:0] A_CUR_END = 5'h0b;
	localparam logic [4:0] A_START_HI = 5'h0c;
	localparam logic [4:0] A_START_LO = 5'h0d;
	localparam logic [4:0] A_CUR_HI = 5'h0e;
	localparam logic [4:0] A_CUR_LO = 5'h0f;
	localparam logic [4:0] A_PEN_HI = 5'h10;
	localparam logic [4:0] A_PEN_LO = 5'h11;
	localparam logic [4:0] A_STATUS = 5'h12;

	// field positions
	localparam int CUR_BLINK_LSB = 5;
	localparam int ST_PEN_BIT = 0;
	localparam int ST_FIELD_BIT = 1;
	localparam int ST_VSYNC_BIT = 2;
	localparam int ST_DISP_BIT = 3;

	// cursor display modes
	localparam logic [1:0] BLINK_STEADY = 2'h0;
	localparam logic [1:0] BLINK_OFF = 2'h1;
	localparam logic [1:0] BLINK_16 = 2'h2;
	localparam logic [1:0] BLINK_32 = 2'h3;
	localparam int BLINK16_BIT = 3;
	localparam int BLINK32_BIT = 4;

	// scan modes
	localparam logic [1:0] SCAN_ILACE_VIDEO = 2'h3;

	// vertical sync width in scan lines
	localparam logic [4:0] VSYNC_LINES = 5'h10;

	typedef struct packed {
		logic [7:0] htotal;
		logic [7:0] hdisp;
		logic [7:0] hsync_pos;
		logic [3:0] hsync_width;
		logic [6:0] vtotal;
		logic [4:0] vadjust;
		logic [6:0] vdisp;
		logic [6:0] vsync_pos;
		logic [1:0] scan_mode;
		logic [4:0] max_raster;
		logic [1:0] blink_mode;
		logic [4:0] cur_start;
		logic [4:0] cur_end;
		logic [13:0] start_addr;
		logic [13:0] cursor_addr;
	} crt_cfg_t;

endpackage

// ==== sync_two_ff.sv ====
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// first stage is read only by the second stage
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== raster_crt_timing_controller.sv ====
// raster display timing controller: counters, sync, refresh address, cursor and light pen
//
// Behaviour
// - drive 14-bit linear refresh memory address
// - line length programmable in character clocks
// - frame height programmable in character rows
// - extra single rasters fine-adjust the frame
// - cursor blinks every 16 or 32 fields
// - 14-bit cursor register compared with address
// - light pen strobe captures current address
// - each frame starts at programmed start address, the first after reset at zero
// - non-interlaced and interlaced odd/even field scanning
// - counters make syncs, window, raster index
// - addresses regenerated every raster, no buffer
// - vertical sync high for 16 lines
// - cursor video forced low outside window
// - reset clears counters, outputs low, keeps settings
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module raster_crt_timing_controller (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic [crt_timing_pkg::ADDR_W-1:0] reg_addr_in,
	input wire logic [crt_timing_pkg::DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [crt_timing_pkg::DATA_W-1:0] reg_rdata_out,
	input wire logic pen_capture_strobe_in,
	output logic hsync_out,
	output logic frame_sync_out,
	output logic display_window_out,
	output logic [crt_timing_pkg::RASTER_W-1:0] row_raster_index_out,
	output logic [crt_timing_pkg::REFRESH_W-1:0] refresh_addr_out,
	output logic cursor_video_out,
	output logic field_odd_out
);
	import crt_timing_pkg::*;

	crt_cfg_t cfg_q;
	logic [7:0] hcnt_q;
	logic [RASTER_W-1:0] raster_q;
	logic [ROW_W-1:0] row_q;
	logic in_adjust_q;
	logic [4:0] adj_cnt_q;
	logic [REFRESH_W-1:0] base_q;
	logic [REFRESH_W-1:0] lin_addr_q;
	logic field_q;
	logic [3:0] hs_cnt_q;
	logic [4:0] vs_cnt_q;
	logic [4:0] blink_cnt_q;
	logic [REFRESH_W-1:0] pen_q;
	logic pen_flag_q;
	logic pen_sync;
	logic pen_prev_q;
	logic pen_edge;
	logic line_end;
	logic row_end;
	logic frame_end;
	logic last_row;
	logic [RASTER_W-1:0] raster_step;
	logic [RASTER_W-1:0] raster_first;
	logic [5:0] raster_next;
	logic disp_now;
	logic cursor_on;
	logic blink_ok;
	logic [REFRESH_W-1:0] base_adv;

	////////////////////////////////////////////////////////////////////////////
	// register writes; settings survive reset on purpose

	always_ff @(posedge clk_in) begin
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				A_HTOTAL: cfg_q.htotal <= reg_wdata_in;
				A_HDISP: cfg_q.hdisp <= reg_wdata_in;
				A_HSYNC_POS: cfg_q.hsync_pos <= reg_wdata_in;
				A_HSYNC_WIDTH: cfg_q.hsync_width <= reg_wdata_in[3:0];
				A_VTOTAL: cfg_q.vtotal <= reg_wdata_in[6:0];
				A_VADJUST: cfg_q.vadjust <= reg_wdata_in[4:0];
				A_VDISP: cfg_q.vdisp <= reg_wdata_in[6:0];
				A_VSYNC_POS: cfg_q.vsync_pos <= reg_wdata_in[6:0];
				A_SCAN_MODE: cfg_q.scan_mode <= reg_wdata_in[1:0];
				A_MAX_RASTER: cfg_q.max_raster <= reg_wdata_in[4:0];
				A_CUR_START: begin
					cfg_q.blink_mode <= reg_wdata_in[CUR_BLINK_LSB+:2];
					cfg_q.cur_start <= reg_wdata_in[4:0];
				end
				A_CUR_END: cfg_q.cur_end <= reg_wdata_in[4:0];
				A_START_HI: cfg_q.start_addr[13:8] <= reg_wdata_in[5:0];
				A_START_LO: cfg_q.start_addr[7:0] <= reg_wdata_in;
				A_CUR_HI: cfg_q.cursor_addr[13:8] <= reg_wdata_in[5:0];
				A_CUR_LO: cfg_q.cursor_addr[7:0] <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register reads, data in the following cycle only

	always_ff @(posedge clk_in) begin
		reg_rdata_out <= 8'h00;
		if (reg_rd_in) begin
			unique case (reg_addr_in)
				A_START_HI: reg_rdata_out <= {2'h0, cfg_q.start_addr[13:8]};
				A_START_LO: reg_rdata_out <= cfg_q.start_addr[7:0];
				A_CUR_HI: reg_rdata_out <= {2'h0, cfg_q.cursor_addr[13:8]};
				A_CUR_LO: reg_rdata_out <= cfg_q.cursor_addr[7:0];
				A_PEN_HI: reg_rdata_out <= {2'h0, pen_q[13:8]};
				A_PEN_LO: reg_rdata_out <= pen_q[7:0];
				A_STATUS: begin
					reg_rdata_out[ST_PEN_BIT] <= pen_flag_q;
					reg_rdata_out[ST_FIELD_BIT] <= field_q;
					reg_rdata_out[ST_VSYNC_BIT] <= frame_sync_out;
					reg_rdata_out[ST_DISP_BIT] <= display_window_out;
				end
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// scan counters

	assign line_end = (hcnt_q == cfg_q.htotal);
	// interlaced video mode steps two rasters per line, odd field starts at one
	assign raster_step = (cfg_q.scan_mode == SCAN_ILACE_VIDEO) ? 5'h02 : 5'h01;
	assign raster_first = (cfg_q.scan_mode == SCAN_ILACE_VIDEO) ? {4'h0, field_q} : 5'h00;
	assign raster_next = {1'b0, raster_q} + {1'b0, raster_step};
	assign row_end = (raster_next > {1'b0, cfg_q.max_raster});
	assign last_row = (row_q == cfg_q.vtotal);
	assign frame_end = line_end && (in_adjust_q ? (adj_cnt_q == cfg_q.vadjust)
		: (row_end && last_row && cfg_q.vadjust == 5'h00));
	assign base_adv = base_q + {6'h00, cfg_q.hdisp};

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			hcnt_q <= 8'h00;
		end else if (line_end) begin
			hcnt_q <= 8'h00;
		end else begin
			hcnt_q <= hcnt_q + 8'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			raster_q <= 5'h00;
			row_q <= 7'h00;
			in_adjust_q <= 1'b0;
			adj_cnt_q <= 5'h00;
			field_q <= 1'b0;
		end else if (line_end) begin
			if (frame_end) begin
				row_q <= 7'h00;
				in_adjust_q <= 1'b0;
				adj_cnt_q <= 5'h00;
				// odd and even fields alternate only when interlaced
				if (cfg_q.scan_mode[0]) begin
					field_q <= ~field_q;
					raster_q <= (cfg_q.scan_mode == SCAN_ILACE_VIDEO) ? {4'h0, ~field_q} : 5'h00;
				end else begin
					field_q <= 1'b0;
					raster_q <= 5'h00;
				end
			end else if (in_adjust_q) begin
				adj_cnt_q <= adj_cnt_q + 5'h01;
			end else if (row_end) begin
				raster_q <= raster_first;
				if (last_row) begin
					in_adjust_q <= 1'b1;
					adj_cnt_q <= 5'h01;
				end else begin
					row_q <= row_q + 7'h01;
				end
			end else begin
				raster_q <= raster_next[RASTER_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// linear address generator; each raster re-reads its row from memory

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			base_q <= 14'h0000;
			lin_addr_q <= 14'h0000;
		end else if (line_end) begin
			if (frame_end) begin
				base_q <= cfg_q.start_addr;
				lin_addr_q <= cfg_q.start_addr;
			end else if (row_end && !in_adjust_q && !last_row) begin
				base_q <= base_adv;
				lin_addr_q <= base_adv;
			end else begin
				lin_addr_q <= base_q;
			end
		end else begin
			lin_addr_q <= lin_addr_q + 14'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sync generation

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			hs_cnt_q <= 4'h0;
		end else if (hcnt_q == cfg_q.hsync_pos && cfg_q.hsync_width != 4'h0) begin
			hs_cnt_q <= cfg_q.hsync_width;
		end else if (hs_cnt_q != 4'h0) begin
			hs_cnt_q <= hs_cnt_q - 4'h1;
		end
	end

	// vertical sync opens on the first line of the programmed row
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			vs_cnt_q <= 5'h00;
		end else if (line_end && row_end && !in_adjust_q && !last_row && (row_q + 7'h01) == cfg_q.vsync_pos) begin
			vs_cnt_q <= VSYNC_LINES;
		end else if (line_end && vs_cnt_q != 5'h00) begin
			vs_cnt_q <= vs_cnt_q - 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cursor and blink

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			blink_cnt_q <= 5'h00;
		end else if (frame_end) begin
			blink_cnt_q <= blink_cnt_q + 5'h01;
		end
	end

	always_comb begin
		unique case (cfg_q.blink_mode)
			BLINK_STEADY: blink_ok = 1'b1;
			BLINK_OFF: blink_ok = 1'b0;
			BLINK_16: blink_ok = blink_cnt_q[BLINK16_BIT];
			BLINK_32: blink_ok = blink_cnt_q[BLINK32_BIT];
		endcase
	end

	assign disp_now = (hcnt_q < cfg_q.hdisp) && (row_q < cfg_q.vdisp) && !in_adjust_q;
	assign cursor_on = (lin_addr_q == cfg_q.cursor_addr) && blink_ok
		&& (raster_q >= cfg_q.cur_start) && (raster_q <= cfg_q.cur_end);

	////////////////////////////////////////////////////////////////////////////
	// output stage; all pins one clock behind the counters, low in reset

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			hsync_out <= 1'b0;
			frame_sync_out <= 1'b0;
			display_window_out <= 1'b0;
			row_raster_index_out <= 5'h00;
			refresh_addr_out <= 14'h0000;
			cursor_video_out <= 1'b0;
			field_odd_out <= 1'b0;
		end else begin
			hsync_out <= (hs_cnt_q != 4'h0);
			frame_sync_out <= (vs_cnt_q != 5'h00);
			display_window_out <= disp_now;
			row_raster_index_out <= raster_q;
			refresh_addr_out <= lin_addr_q;
			cursor_video_out <= disp_now && cursor_on;
			field_odd_out <= field_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// light pen; the strobe pin is asynchronous to the character clock

	sync_two_ff #(
		.WIDTH(1)
	) pen_sync_u (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.async_in(pen_capture_strobe_in),
		.sync_out(pen_sync)
	);

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pen_prev_q <= 1'b0;
		end else begin
			pen_prev_q <= pen_sync;
		end
	end

	assign pen_edge = pen_sync && !pen_prev_q;

	// capture the address shown on the pins; software corrects for pen delay
	always_ff @(posedge clk_in) begin
		if (pen_edge && nrst_in) begin
			pen_q <= refresh_addr_out;
		end
	end

	// a new capture wins over the clear by reading the low byte
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			pen_flag_q <= 1'b0;
		end else if (pen_edge) begin
			pen_flag_q <= 1'b1;
		end else if (reg_rd_in && reg_addr_in == A_PEN_LO) begin
			pen_flag_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [4:0] vs_lines_q;

	always_ff @(posedge clk_in) begin
		if (!nrst_in || vs_cnt_q == 5'h00) begin
			vs_lines_q <= 5'h00;
		end else if (line_end) begin
			vs_lines_q <= vs_lines_q + 5'h01;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	a_vsync_lines: assert property ($fell(vs_cnt_q != 5'h00) |-> vs_lines_q == VSYNC_LINES)
		else $error("vertical sync not sixteen lines long");
	a_cursor_window: assert property (cursor_video_out |-> display_window_out)
		else $error("cursor video outside display window");
	a_reset_low: assert property (disable iff (1'b0) !nrst_in |=> refresh_addr_out == 14'h0000
		&& !hsync_out && !frame_sync_out && !cursor_video_out && hcnt_q == 8'h00)
		else $error("outputs not cleared by reset");
	a_pen_capture: assert property (pen_edge |=> pen_q == $past(refresh_addr_out) && pen_flag_q)
		else $error("light pen address not captured");
	a_addr_step: assert property (!line_end |=> lin_addr_q == $past(lin_addr_q) + 14'h0001)
		else $error("refresh address did not advance");
	a_frame_start: assert property (frame_end |=> lin_addr_q == $past(cfg_q.start_addr) && row_q == 7'h00)
		else $error("frame did not restart at start address");
	a_row_advance: assert property (line_end && row_end && !in_adjust_q && !last_row
		|=> base_q == $past(base_adv) && raster_q == raster_first)
		else $error("row base or raster index wrong at row end");
	a_line_wrap: assert property (line_end |=> hcnt_q == 8'h00 ##[1:256] line_end)
		else $error("horizontal counter did not wrap");
	a_hsync_start: assert property (hcnt_q == cfg_q.hsync_pos && cfg_q.hsync_width != 4'h0
		|-> ##2 hsync_out)
		else $error("horizontal sync did not start");

	c_frame_end: cover property (frame_end);
	c_pen_hit: cover property (pen_edge && display_window_out);
	c_cursor_shown: cover property (cursor_video_out);
	c_odd_field: cover property (field_q && frame_end);

endmodule
`default_nettype wire

// ==== crt_far_side.sv ====
// far-side model: monitor timing probe, refresh memory address probe, light pen
`timescale 1ns/1ps
`default_nettype none
module crt_far_side (
	input wire logic clk_in,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic window_in,
	input wire logic cursor_in,
	input wire logic field_in,
	input wire logic [4:0] raster_in,
	input wire logic [13:0] addr_in,
	input wire logic pen_arm_in,
	input wire logic [13:0] pen_target_in,
	output logic pen_out,
	output logic [11:0][15:0] meas_out
);
	logic hs_d, vs_d, win_d, fired, shown_q, fld_q, shown;
	logic [15:0] hcnt, hw, fcnt, vw, cur_acc, run;
	logic [2:0] pc;
	logic [3:0] wl;
	initial begin
		{hs_d, vs_d, win_d, fired, shown_q, fld_q, pen_out} = '0;
		{hcnt, hw, fcnt, vw, cur_acc, run, pc, wl} = '0;
		meas_out = '0;
	end
	assign shown = (cur_acc != 16'h0000);
	always @(posedge clk_in) begin
		hs_d <= hsync_in;
		vs_d <= vsync_in;
		win_d <= window_in;
		hcnt <= (hsync_in && !hs_d) ? 16'h0001 : hcnt + 16'h0001;
		fcnt <= (vsync_in && !vs_d) ? 16'h0001 : fcnt + 16'h0001;
		hw <= hsync_in ? hw + 16'h0001 : 16'h0000;
		vw <= vsync_in ? vw + 16'h0001 : 16'h0000;
		if (hsync_in && !hs_d) meas_out[0] <= hcnt;
		if (!hsync_in && hs_d) meas_out[1] <= hw;
		if (!vsync_in && vs_d) meas_out[3] <= vw;
		cur_acc <= cur_acc + {15'h0000, cursor_in};
		if (cursor_in && !window_in) meas_out[8] <= meas_out[8] + 16'h0001;
		// first three display lines of a frame; raster index rides in the top two bits
		if (window_in && !win_d) begin
			if (wl < 4'h3) meas_out[4 + wl] <= {raster_in[1:0], addr_in};
			wl <= wl + 4'h1;
		end
		if (vsync_in && !vs_d) begin
			meas_out[2] <= fcnt;
			meas_out[7] <= cur_acc;
			cur_acc <= 16'h0000;
			wl <= 4'h0;
			run <= (shown != shown_q) ? 16'h0001 : run + 16'h0001;
			if (shown != shown_q) meas_out[9] <= run;
			shown_q <= shown;
			meas_out[10] <= {15'h0000, field_in ^ fld_q};
			fld_q <= field_in;
		end
		meas_out[11] <= {15'h0000, |{hsync_in, vsync_in, window_in, cursor_in, field_in, raster_in, addr_in}};
		// a pen sees one spot once; held a few clocks as a real strobe would be
		if (!pen_arm_in) begin
			fired <= 1'b0;
			pen_out <= 1'b0;
		end else if (!fired && addr_in == pen_target_in) begin
			pen_out <= 1'b1;
			fired <= 1'b1;
			pc <= 3'h4;
		end else if (pc != 3'h0) begin
			pc <= pc - 3'h1;
			if (pc == 3'h1) pen_out <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the raster timing controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import crt_timing_pkg::*;
	logic clk_in, nrst_in, reg_wr_in, reg_rd_in, pen, hsync_out, frame_sync_out, win, cur, fld, snap, rd_d, pen_arm;
	logic [4:0] reg_addr_in, rast;
	logic [7:0] reg_wdata_in, reg_rdata_out;
	logic [13:0] rfa, st, st2, pen_target;
	logic [11:0][15:0] meas;
	logic [7:0] rd_q[$];
	logic [15:0] m_q[$];
	int msel, num_errors, tests_run, seed;
	raster_crt_timing_controller u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.pen_capture_strobe_in(pen), .hsync_out(hsync_out), .frame_sync_out(frame_sync_out),
		.display_window_out(win), .row_raster_index_out(rast), .refresh_addr_out(rfa), .cursor_video_out(cur),
		.field_odd_out(fld));
	crt_far_side u_far (.clk_in(clk_in), .hsync_in(hsync_out), .vsync_in(frame_sync_out), .window_in(win),
		.cursor_in(cur), .field_in(fld), .raster_in(rast), .addr_in(rfa), .pen_arm_in(pen_arm),
		.pen_target_in(pen_target), .pen_out(pen), .meas_out(meas));
	always #10 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////////////
	task results();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task cmp_rd(input logic [7:0] got, input logic [7:0] e);
		tests_run++;
		if (got !== e) begin
			num_errors++;
			$display("ERROR %0t read data %h expected %h", $time, got, e);
		end
	endtask
	task cmp_m(input int i, input logic [15:0] got, input logic [15:0] e);
		tests_run++;
		if (got !== e) begin
			num_errors++;
			$display("ERROR %0t measure %0d got %h expected %h", $time, i, got, e);
		end
	endtask
	// results appear one cycle after a read strobe, or when a measure snapshot is taken
	always @(posedge clk_in) begin
		if (rd_d) cmp_rd(reg_rdata_out, rd_q.pop_front());
		if (snap) cmp_m(msel, meas[msel], m_q.pop_front());
		rd_d <= reg_rd_in;
	end
	////////////////////////////////////////////////////////////////////////
	task bus(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
		reg_wr_in <= w;
		reg_rd_in <= r;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge clk_in);
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask
	task set14(input logic [4:0] ah, input logic [13:0] v);
		wr(ah, {2'b00, v[13:8]});
		wr(ah + 5'h01, v[7:0]);
	endtask
	task chk(input int i, input logic [15:0] e);
		m_q.push_back(e);
		msel <= i;
		snap <= 1'b1;
		@(posedge clk_in);
		snap <= 1'b0;
		@(posedge clk_in);
	endtask
	task frames(input int n);
		repeat (n) @(posedge frame_sync_out);
		@(posedge clk_in);
	endtask
	// 8 clocks a line, 2 lines a row, 20 rows plus 3 lines a frame
	task prog(input logic [13:0] s);
		wr(A_HTOTAL, 8'h07);
		wr(A_HDISP, 8'h05);
		wr(A_HSYNC_POS, 8'h03);
		wr(A_HSYNC_WIDTH, 8'h02);
		wr(A_VTOTAL, 8'h13);
		wr(A_VADJUST, 8'h03);
		wr(A_VDISP, 8'h03);
		wr(A_VSYNC_POS, 8'h04);
		wr(A_SCAN_MODE, 8'h00);
		wr(A_MAX_RASTER, 8'h01);
		wr(A_CUR_START, {1'b0, BLINK_STEADY, 5'h00});
		wr(A_CUR_END, 8'h01);
		set14(A_START_HI, s);
		set14(A_CUR_HI, s + 14'h0007);
		bus(1'b0, 1'b0, 5'h00, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		{clk_in, nrst_in, reg_wr_in, reg_rd_in, snap, rd_d, pen_arm} = '0;
		{reg_addr_in, reg_wdata_in, pen_target, msel, num_errors, tests_run} = '0;
		seed = 18;
		st = 14'($random(seed));
		st2 = 14'($random(seed));
		@(posedge clk_in);
		// settings survive reset, so they are loaded while it is held
		prog(st);
		repeat (5) @(posedge clk_in);
		chk(11, 16'h0000);
		nrst_in <= 1'b1;
		frames(3);
		chk(0, 16'd8);
		chk(1, 16'd2);
		chk(2, 16'd344);
		chk(3, 16'd128);
		chk(4, {2'b00, st});
		chk(5, {2'b01, st});
		chk(6, {2'b00, st + 14'h0005});
		chk(7, 16'd2);
		chk(8, 16'd0);
		wr(5'h13, 8'h5a);
		rd(5'h13, 8'h00);
		rd(A_HTOTAL, 8'h00);
		rd(A_START_HI, {2'b00, st[13:8]});
		rd(A_START_LO, st[7:0]);
		rd(A_CUR_LO, 8'(st + 14'h0007));
		bus(1'b0, 1'b0, 5'h00, 8'h00);
		pen_target <= st + 14'h0001;
		pen_arm <= 1'b1;
		frames(2);
		pen_arm <= 1'b0;
		rd(A_STATUS, 8'h05);
		rd(A_PEN_HI, {2'b00, 6'((st + 14'h0004) >> 8)});
		rd(A_PEN_LO, 8'(st + 14'h0004));
		rd(A_STATUS, 8'h04);
		set14(A_START_HI, st2);
		set14(A_CUR_HI, st2 + 14'h0007);
		wr(A_CUR_START, {1'b0, BLINK_OFF, 5'h00});
		bus(1'b0, 1'b0, 5'h00, 8'h00);
		frames(2);
		chk(4, {2'b00, st2});
		chk(6, {2'b00, st2 + 14'h0005});
		chk(7, 16'd0);
		nrst_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk(11, 16'h0000);
		nrst_in <= 1'b1;
		frames(2);
		chk(4, {2'b00, st2});
		chk(0, 16'd8);
		wr(A_CUR_START, {1'b0, BLINK_16, 5'h00});
		bus(1'b0, 1'b0, 5'h00, 8'h00);
		frames(30);
		chk(9, 16'd8);
		wr(A_CUR_START, {1'b0, BLINK_32, 5'h00});
		bus(1'b0, 1'b0, 5'h00, 8'h00);
		frames(56);
		chk(9, 16'd16);
		wr(A_SCAN_MODE, 8'h01);
		bus(1'b0, 1'b0, 5'h00, 8'h00);
		frames(3);
		chk(10, 16'd1);
		// interlace video: one line a row, raster index follows the field
		wr(A_SCAN_MODE, {6'h00, SCAN_ILACE_VIDEO});
		bus(1'b0, 1'b0, 5'h00, 8'h00);
		frames(2);
		chk(4, {2'b01, st2});
		chk(5, {2'b01, st2 + 14'h0005});
		results();
	end
	// about 100 frames of 344 clocks are needed; cut a hang well beyond that
	initial begin
		repeat (60000) @(posedge clk_in);
		num_errors++;
		results();
	end
endmodule
`default_nettype wire
